// [design/accel_readout_pkg.sv]
// Purpose: shared constants for the accelerometer status readout registers
// Assumes: 25 MHz core clock, 8-bit register addresses and data
// Notes: offsets, field positions, latch codes and hold timing live here
package accel_readout_pkg;

    // register offsets on the register port
    localparam logic [7:0] ADDR_Z_LOW   = 8'h06;  // accel_z_low_reg
    localparam logic [7:0] ADDR_Z_UPPER = 8'h07;  // accel_z_upper_reg
    localparam logic [7:0] ADDR_TEMP    = 8'h08;  // die_heat_reading
    localparam logic [7:0] ADDR_MOTION  = 8'h09;  // motion_event_flags
    localparam logic [7:0] ADDR_QUEUE   = 8'h0a;  // sample_queue_event_flags
    localparam logic [7:0] ADDR_AXIS    = 8'h0b;  // knock_motion_axis_flags

    // motion_event_flags bit positions
    localparam int MOT_LOW    = 0;
    localparam int MOT_HIGH   = 1;
    localparam int MOT_SLOPE  = 2;
    localparam int MOT_NOMOT  = 3;
    localparam int MOT_DTAP   = 4;
    localparam int MOT_STAP   = 5;
    localparam int MOT_ORIENT = 6;
    localparam int MOT_FLAT   = 7;

    // sample_queue_event_flags bit positions, bits 4:0 read zero
    localparam int QUE_FULL  = 5;
    localparam int QUE_LEVEL = 6;
    localparam int QUE_DRDY  = 7;

    // knock_motion_axis_flags field positions
    localparam int AXIS_SLOPE_LSB = 0;
    localparam int AXIS_SLOPE_SGN = 3;
    localparam int AXIS_TAP_LSB   = 4;
    localparam int AXIS_TAP_SGN   = 7;

    // event flags: 8 motion flags followed by 3 queue flags
    localparam int NUM_FLAGS = 11;

    // latch-mode codes; every other code means a temporary hold
    localparam logic [3:0] LATCH_NONE = 4'h0;
    localparam logic [3:0] LATCH_PERM = 4'hf;

    // temporary hold time and its cycle count
    localparam int CORE_CLK_HZ      = 25_000_000;
    localparam int TEMP_HOLD_MS     = 250;
    localparam int TEMP_HOLD_CYCLES = CORE_CLK_HZ / 1000 * TEMP_HOLD_MS;

endpackage : accel_readout_pkg

// [design/accel_status_readout_regs.sv]
// Purpose: Z sample, temperature and interrupt status readout registers
// Assumes: all inputs come from logic on core_clk, register port is synchronous
// Notes: read data appears one cycle after the read strobe; writes are dropped
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Low-byte read freezes upper byte until read
// - burst low-then-upper read returns consistent pair
// - upper byte holds sample bits 11:4
// - temperature two's-complement, zero means 23 C
// - status flag sets when its function triggers
// - latch mode sets none, temporary, permanent hold
// - flags only for enabled functions
// - motion flags register bit layout
// - queue flags in bits 7:5, rest zero
// - tap sign and axis in bits 7:4
// - slope sign and axis in bits 3:0
// - low byte: sample bits 3:0, new-data flag
module accel_status_readout_regs #(
    parameter int HOLD_CYCLES = accel_readout_pkg::TEMP_HOLD_CYCLES  // temporary latch hold
) (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // register port
    input  wire logic        regRd,          // one-cycle read strobe
    input  wire logic        regWr,          // one-cycle write strobe, ignored
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    output var  logic [7:0]  regRdData,
    output var  logic        regRdValid,
    // sample and temperature sources
    input  wire logic        sampleValid,    // new Z sample pulse
    input  wire logic [11:0] sampleZ,        // two's-complement Z sample
    input  wire logic [7:0]  dieTemp,        // live temperature code
    input  wire logic        lockDisable,    // disables low/upper readout locking
    // interrupt engines
    input  wire logic [7:0]  motionTrig,     // per motion function trigger
    input  wire logic [7:0]  motionEn,       // per motion function enable
    input  wire logic [2:0]  queueTrig,      // full, level reached, data ready
    input  wire logic [2:0]  queueEn,
    input  wire logic [3:0]  latchMode,
    input  wire logic        clearLatched,   // clears held flags
    // tap and slope origin
    input  wire logic        tapSign,
    input  wire logic [2:0]  tapAxis,        // z, y, x
    input  wire logic        slopeSign,
    input  wire logic [2:0]  slopeAxis       // z, y, x
);
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("HOLD_CYCLES must be at least one");
    end

    typedef struct packed {
        logic [11:0] sample;   // newest Z sample
        logic [7:0]  upper;    // upper byte image, frozen while locked
        logic        locked;   // low byte read, upper not yet read
        logic        newData;  // sample updated since last low read
        logic [7:0]  temp;     // registered temperature
        logic [7:0]  axis;     // tap and slope origin
        logic [7:0]  rdData;   // read data out
        logic        rdValid;  // read data valid
    } regs_state_t;

    regs_state_t cur_q;  // registered state
    regs_state_t nxt_d;  // next state

    logic [accel_readout_pkg::NUM_FLAGS-1:0] flagTrig;  // enabled triggers
    logic [accel_readout_pkg::NUM_FLAGS-1:0] flagHeld;  // held flags
    logic [7:0] motionFlags;
    logic [7:0] queueFlags;
    logic       readLow;
    logic       readUpper;
    logic       tapHit;
    logic       slopeHit;

    // a flag only ever sees triggers of enabled functions
    assign flagTrig = {queueTrig & queueEn, motionTrig & motionEn};
    assign readLow   = regRd && regAddr == accel_readout_pkg::ADDR_Z_LOW;
    assign readUpper = regRd && regAddr == accel_readout_pkg::ADDR_Z_UPPER;
    assign tapHit    = flagTrig[accel_readout_pkg::MOT_STAP] || flagTrig[accel_readout_pkg::MOT_DTAP];
    assign slopeHit  = flagTrig[accel_readout_pkg::MOT_SLOPE];

    // one holder per flag, all sharing the latch mode
    for (genvar i = 0; i < accel_readout_pkg::NUM_FLAGS; i++) begin : g_flag
        event_latch #(
            .HOLD_CYCLES (HOLD_CYCLES)
        ) u_latch (
            .core_clk     (core_clk),
            .rst          (rst),
            .trigger      (flagTrig[i]),
            .latchMode    (latchMode),
            .clearLatched (clearLatched),
            .flag         (flagHeld[i])
        );
    end

    // motion flags keep their index order, queue flags sit in bits 7:5
    assign motionFlags = flagHeld[7:0];
    assign queueFlags  = {flagHeld[10:8], 5'h00};

    // next-state: sample tracking, lock, origin capture and read mux
    always_comb begin
        nxt_d         = cur_q;
        nxt_d.rdValid = regRd;  // writes never produce an answer
        nxt_d.temp    = dieTemp;
        if (sampleValid) begin
            nxt_d.sample = sampleZ;
        end
        // new-data: a fresh sample wins over the clear by a low read
        if (sampleValid) begin
            nxt_d.newData = 1'b1;
        end else if (readLow) begin
            nxt_d.newData = 1'b0;
        end
        // lock taken by a low read, released by an upper read
        if (readLow && !lockDisable) begin
            nxt_d.locked = 1'b1;
        end else if (readUpper || lockDisable) begin
            nxt_d.locked = 1'b0;
        end
        // upper image follows the sample only when unlocked; the lock takes effect
        // in the very cycle of the low read so a burst sees one sample
        if (!cur_q.locked && !(readLow && !lockDisable)) begin
            nxt_d.upper = nxt_d.sample[11:4];
        end
        // origin fields are captured with their events
        if (tapHit) begin
            nxt_d.axis[accel_readout_pkg::AXIS_TAP_SGN] = tapSign;
            nxt_d.axis[accel_readout_pkg::AXIS_TAP_LSB +: 3] = tapAxis;
        end
        if (slopeHit) begin
            nxt_d.axis[accel_readout_pkg::AXIS_SLOPE_SGN] = slopeSign;
            nxt_d.axis[accel_readout_pkg::AXIS_SLOPE_LSB +: 3] = slopeAxis;
        end
        // read mux; unmapped offsets read zero
        if (regRd) begin
            unique case (regAddr)
                accel_readout_pkg::ADDR_Z_LOW:   nxt_d.rdData = {cur_q.sample[3:0], 3'h0, cur_q.newData};
                accel_readout_pkg::ADDR_Z_UPPER: nxt_d.rdData = cur_q.upper;
                accel_readout_pkg::ADDR_TEMP:    nxt_d.rdData = cur_q.temp;
                accel_readout_pkg::ADDR_MOTION:  nxt_d.rdData = motionFlags;
                accel_readout_pkg::ADDR_QUEUE:   nxt_d.rdData = queueFlags;
                accel_readout_pkg::ADDR_AXIS:    nxt_d.rdData = cur_q.axis;
                default:                         nxt_d.rdData = 8'h00;
            endcase
        end
        // regWr and regWrData touch nothing: every register here is read-only
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign regRdData  = cur_q.rdData;
    assign regRdValid = cur_q.rdValid;

    // reads of the upper byte in power-up or the lowest_power_state are the host's
    // concern; this logic answers them with whatever image it holds

    // a low read that takes the lock; a write in the same cycle is not expected
    sequence lowRead_s;
        readLow && !lockDisable && !regWr;
    endsequence

    // the upper read that completes a locked pair
    sequence upperRead_s;
        readUpper && !lockDisable;
    endsequence

    // a lock that nothing releases in this cycle
    sequence lockHeld_s;
        cur_q.locked && !readUpper && !lockDisable;
    endsequence

    chk_lock_freeze : assert property (@(posedge core_clk) disable iff (rst)
        lockHeld_s |=> $stable(cur_q.upper))
        else $error("upper byte changed while locked");

    chk_burst_pair : assert property (@(posedge core_clk) disable iff (rst)
        (lowRead_s ##1 upperRead_s) |=> regRdData == $past(cur_q.upper, 2))
        else $error("burst read returned an inconsistent upper byte");

    chk_upper_layout : assert property (@(posedge core_clk) disable iff (rst)
        (!cur_q.locked && !readLow) |=> cur_q.upper == cur_q.sample[11:4])
        else $error("unlocked upper byte does not match sample bits 11:4");

    chk_temp_readout : assert property (@(posedge core_clk) disable iff (rst)
        (regRd && regAddr == accel_readout_pkg::ADDR_TEMP) |=> regRdValid && regRdData == $past(cur_q.temp))
        else $error("temperature read returned wrong value");

    chk_motion_event : assert property (@(posedge core_clk) disable iff (rst)
        flagTrig[accel_readout_pkg::MOT_SLOPE] |=> motionFlags[accel_readout_pkg::MOT_SLOPE])
        else $error("slope flag not set after an enabled trigger");

    chk_flag_enabled : assert property (@(posedge core_clk) disable iff (rst)
        $rose(motionFlags[accel_readout_pkg::MOT_LOW]) |-> $past(motionEn[accel_readout_pkg::MOT_LOW]))
        else $error("low-g flag rose while its function was disabled");

    chk_motion_readout : assert property (@(posedge core_clk) disable iff (rst)
        (regRd && regAddr == accel_readout_pkg::ADDR_MOTION) |=> regRdData == $past(flagHeld[7:0]))
        else $error("motion flag read does not match held flags");

    chk_queue_reserved : assert property (@(posedge core_clk) disable iff (rst)
        (regRd && regAddr == accel_readout_pkg::ADDR_QUEUE) |=> regRdData[4:0] == 5'h00
            && regRdData[7:5] == $past(flagHeld[10:8]))
        else $error("queue flag read has wrong layout");

    chk_tap_axis : assert property (@(posedge core_clk) disable iff (rst)
        tapHit |=> cur_q.axis[7:4] == $past({tapSign, tapAxis}))
        else $error("tap origin not captured");

    chk_slope_axis : assert property (@(posedge core_clk) disable iff (rst)
        slopeHit |=> cur_q.axis[3:0] == $past({slopeSign, slopeAxis}))
        else $error("slope origin not captured");

    chk_new_data : assert property (@(posedge core_clk) disable iff (rst)
        sampleValid |=> cur_q.newData)
        else $error("new-data flag not set by a sample");

    chk_new_clear : assert property (@(posedge core_clk) disable iff (rst)
        (readLow && !sampleValid) |=> !cur_q.newData)
        else $error("new-data flag not cleared by a low read");

    chk_write_ignored : assert property (@(posedge core_clk) disable iff (rst)
        (regWr && !regRd && !tapHit && !slopeHit) |=> !regRdValid && $stable(cur_q.axis))
        else $error("write produced an answer or changed a register");

    // answer path: one answer per read strobe on the next edge and none otherwise;
    // the data word then stands until the next read, so a slow host can still take it
    // and a dropped write leaves no trace on the port
    chk_read_answer : assert property (@(posedge core_clk) disable iff (rst)
        regRd |=> regRdValid)
        else $error("read strobe got no answer on the next edge");

    chk_no_stray_answer : assert property (@(posedge core_clk) disable iff (rst)
        !regRd |=> !regRdValid)
        else $error("answer appeared without a read strobe");

    chk_data_holds : assert property (@(posedge core_clk) disable iff (rst)
        !regRd |=> $stable(regRdData))
        else $error("read data moved without a read");

    // lock steps: taken by a low read with locking on, dropped by an upper read or
    // by disabling the lock; a host that never reads the upper byte keeps it frozen
    chk_lock_taken : assert property (@(posedge core_clk) disable iff (rst)
        (readLow && !lockDisable) |=> cur_q.locked)
        else $error("low read did not take the lock");

    chk_lock_release : assert property (@(posedge core_clk) disable iff (rst)
        (readUpper || lockDisable) |=> !cur_q.locked)
        else $error("lock not released by an upper read or by disabling it");

    chk_upper_read : assert property (@(posedge core_clk) disable iff (rst)
        readUpper |=> regRdData == $past(cur_q.upper))
        else $error("upper read did not return the held image");

    // low byte: sample nibble on top, spare bits read zero, new-data flag at the bottom
    chk_low_layout : assert property (@(posedge core_clk) disable iff (rst)
        readLow |=> regRdData == {$past(cur_q.sample[3:0]), 3'h0, $past(cur_q.newData)})
        else $error("low byte read has wrong layout");

    // temperature register follows the live code one edge late
    chk_temp_track : assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> cur_q.temp == $past(dieTemp))
        else $error("temperature register missed the live code");

    // offsets outside the map answer zero rather than a stale word
    chk_unmapped_zero : assert property (@(posedge core_clk) disable iff (rst)
        (regRd && (regAddr < accel_readout_pkg::ADDR_Z_LOW || regAddr > accel_readout_pkg::ADDR_AXIS))
            |=> regRdData == 8'h00)
        else $error("unmapped offset did not read zero");

    // flags beyond the slope case: single taps and data-ready set the same way, the
    // data-ready flag obeys its enable too, and with no latching a motion flag is its trigger
    chk_tap_event : assert property (@(posedge core_clk) disable iff (rst)
        flagTrig[accel_readout_pkg::MOT_STAP] |=> motionFlags[accel_readout_pkg::MOT_STAP])
        else $error("single tap flag not set after an enabled trigger");

    chk_drdy_event : assert property (@(posedge core_clk) disable iff (rst)
        flagTrig[accel_readout_pkg::NUM_FLAGS-1] |=> queueFlags[accel_readout_pkg::QUE_DRDY])
        else $error("data-ready flag not set after an enabled trigger");

    chk_queue_enabled : assert property (@(posedge core_clk) disable iff (rst)
        $rose(queueFlags[accel_readout_pkg::QUE_DRDY]) |-> $past(queueEn[2]))
        else $error("data-ready flag rose while its function was disabled");

    chk_none_follows : assert property (@(posedge core_clk) disable iff (rst)
        (latchMode == accel_readout_pkg::LATCH_NONE) |=> motionFlags == $past(motionTrig & motionEn))
        else $error("unlatched motion flags do not follow their triggers");

    // origin fields only move with their own events
    chk_axis_hold : assert property (@(posedge core_clk) disable iff (rst)
        (!tapHit && !slopeHit) |=> $stable(cur_q.axis))
        else $error("origin fields changed without an event");

endmodule : accel_status_readout_regs
`default_nettype wire

// [design/event_latch.sv]
// Purpose: holds one interrupt status flag according to the latch mode
// Assumes: trigger is already gated by the function's enable
// Notes: a new trigger wins over a clear arriving in the same cycle
`timescale 1ns/1ps
`default_nettype none
module event_latch #(
    parameter int HOLD_CYCLES = accel_readout_pkg::TEMP_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // event and control
    input  wire logic       trigger,
    input  wire logic [3:0] latchMode,
    input  wire logic       clearLatched,
    // held flag
    output var  logic       flag
);
    localparam int CW = $clog2(HOLD_CYCLES + 1);

    typedef struct packed {
        logic          flag;   // visible status flag
        logic [CW-1:0] left;   // cycles left in a temporary hold
    } latch_state_t;

    latch_state_t cur_q;  // registered state
    latch_state_t nxt_d;  // next state

    // next-state: mode decides how long a trigger stays visible
    always_comb begin
        nxt_d = cur_q;
        if (latchMode == accel_readout_pkg::LATCH_NONE) begin
            nxt_d.flag = trigger;
            nxt_d.left = '0;
        end else if (latchMode == accel_readout_pkg::LATCH_PERM) begin
            // set wins over the clear, so no event is lost
            if (trigger) begin
                nxt_d.flag = 1'b1;
            end else if (clearLatched) begin
                nxt_d.flag = 1'b0;
            end
        end else begin
            if (trigger) begin
                nxt_d.flag = 1'b1;
                nxt_d.left = CW'(HOLD_CYCLES - 1);
            end else if (clearLatched || cur_q.left == '0) begin
                nxt_d.flag = 1'b0;
            end else begin
                nxt_d.left = cur_q.left - CW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign flag = cur_q.flag;

    chk_perm_hold : assert property (@(posedge core_clk) disable iff (rst)
        (cur_q.flag && latchMode == accel_readout_pkg::LATCH_PERM && !clearLatched) |=> cur_q.flag)
        else $error("permanently latched flag dropped without a clear");

endmodule : event_latch
`default_nettype wire

// [dv/accel_status_readout_regs_bench.sv]
// Purpose: self-checking bench for the Z, temperature and status readout registers
// Assumes: host model issues reads at the falling edge, answers checked in order
// Notes: hold time shortened to 8 cycles so temporary latching fits the run
`timescale 1ns/1ps
`default_nettype none
module accel_status_readout_regs_bench;
    localparam int HOLD = 8;  // shortened temporary hold
    // design signals
    logic        core_clk, rst, regRd, regWr, regRdValid, sampleValid, lockDisable;
    logic        clearLatched, tapSign, slopeSign;
    logic [7:0]  regAddr, regWrData, regRdData, dieTemp, motionTrig, motionEn;
    logic [2:0]  queueTrig, queueEn, tapAxis, slopeAxis;
    logic [3:0]  latchMode;
    logic [11:0] sampleZ;
    // bench state
    logic [7:0]  expQ[$];                                  // expected answers in order
    logic [11:0] s[4];                                     // random samples
    logic [7:0]  tv[4] = '{8'h00, 8'h7f, 8'h80, 8'h00};   // temperature codes
    logic [3:0]  mode[3] = '{4'h0, 4'h3, 4'hf};           // none, temporary, permanent
    logic [7:0]  t, held, ax;
    int          errors = 0, n_compared = 0, cycles = 0, seed;

    accel_status_readout_regs #(.HOLD_CYCLES(HOLD)) u_accel_status_readout_regs (
        .core_clk(core_clk), .rst(rst), .regRd(regRd), .regWr(regWr), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .sampleValid(sampleValid), .sampleZ(sampleZ), .dieTemp(dieTemp), .lockDisable(lockDisable),
        .motionTrig(motionTrig), .motionEn(motionEn), .queueTrig(queueTrig), .queueEn(queueEn),
        .latchMode(latchMode), .clearLatched(clearLatched), .tapSign(tapSign), .tapAxis(tapAxis),
        .slopeSign(slopeSign), .slopeAxis(slopeAxis));
    host_reg_master u_host_reg_master (
        .core_clk(core_clk), .regRd(regRd), .regWr(regWr), .regAddr(regAddr), .regWrData(regWrData));

    // 25 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // verdict and end of run
    task automatic tally_and_finish();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // byte compare, four-state exact
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    // note the expected answer, then let the host read
    task automatic rdx(input logic [7:0] a, input logic [7:0] exp, input bit keep);
        expQ.push_back(exp);
        u_host_reg_master.rd(a, keep);
    endtask : rdx

    // one new-sample pulse
    task automatic newSample(input logic [11:0] v);
        @(negedge core_clk);
        sampleValid = 1'b1;
        sampleZ     = v;
        @(negedge core_clk);
        sampleValid = 1'b0;
        sampleZ     = ~v;
    endtask : newSample

    // a hang counts as a mismatch
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish();
        end
    end

    // answer watcher: oldest note against each answer; a write must never answer
    always @(negedge core_clk) begin
        if (regRdValid === 1'b1) begin
            if (expQ.size() == 0) begin
                errors++;
                $display("[ERR] regRdValid expected 0 seen 1");
            end else begin
                chk8("regRdData", expQ.pop_front(), regRdData);
            end
        end
    end

    initial begin
        {rst, sampleValid, lockDisable, clearLatched, tapSign, slopeSign} = 6'b100000;
        {sampleZ, dieTemp, motionTrig, motionEn, queueTrig, queueEn} = '0;
        {latchMode, tapAxis, slopeAxis} = '0;
        seed = $urandom(94243);
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        chk8("reset regRdData", 8'h00, regRdData);
        chk8("reset regRdValid", 8'h00, {7'h00, regRdValid});
        // upper byte frozen after a low read, also across a burst
        foreach (s[i]) s[i] = 12'($urandom);
        newSample(s[0]);
        rdx(8'h06, {s[0][3:0], 3'h0, 1'b1}, 0);
        newSample(s[1]);
        rdx(8'h07, s[0][11:4], 0);
        rdx(8'h06, {s[1][3:0], 3'h0, 1'b1}, 1);
        fork
            rdx(8'h07, s[1][11:4], 0);
            newSample(s[2]);
        join
        rdx(8'h07, s[2][11:4], 0);
        lockDisable = 1'b1;
        rdx(8'h06, {s[2][3:0], 3'h0, 1'b1}, 0);
        newSample(s[3]);
        rdx(8'h07, s[3][11:4], 0);
        lockDisable = 1'b0;
        rdx(8'h06, {s[3][3:0], 3'h0, 1'b1}, 0);
        rdx(8'h06, {s[3][3:0], 3'h0, 1'b0}, 0);
        // temperature codes including sign boundary
        tv[3] = 8'($urandom);
        foreach (tv[i]) begin
            dieTemp = tv[i];
            repeat (2) @(negedge core_clk);
            rdx(8'h08, tv[i], 0);
        end
        // each latch mode: set, after drop, after hold, after clear
        foreach (mode[m]) begin
            latchMode  = mode[m];
            t          = 8'($urandom);
            motionEn   = 8'($urandom);
            queueEn    = 3'h7;
            motionTrig = t;
            queueTrig  = t[2:0];
            repeat (2) @(negedge core_clk);
            rdx(8'h09, t & motionEn, 0);
            rdx(8'h0a, {t[2:0], 5'h00}, 0);
            motionTrig = 8'h00;
            queueTrig  = 3'h0;
            repeat (2) @(negedge core_clk);
            held = (mode[m] == 4'h0) ? 8'h00 : t & motionEn;
            rdx(8'h09, held, 0);
            repeat (HOLD + 4) @(negedge core_clk);
            held = (mode[m] == 4'hf) ? t & motionEn : 8'h00;
            rdx(8'h09, held, 0);
            rdx(8'h0a, (mode[m] == 4'hf) ? {t[2:0], 5'h00} : 8'h00, 0);
            clearLatched = 1'b1;
            @(negedge core_clk);
            clearLatched = 1'b0;
            @(negedge core_clk);
            rdx(8'h09, 8'h00, 0);
        end
        // tap and slope origin captured only on their own events
        latchMode = 4'h0;
        motionEn  = 8'hff;
        ax        = 8'($urandom);
        {tapSign, tapAxis, slopeSign, slopeAxis} = ax;
        motionTrig = 8'h24;  // single tap and slope
        @(negedge core_clk);
        motionTrig = 8'h00;
        {tapSign, tapAxis, slopeSign, slopeAxis} = ~ax;  // must not show without an event
        rdx(8'h0b, ax, 0);
        motionTrig = 8'h10;  // double tap only
        @(negedge core_clk);
        motionTrig = 8'h00;
        rdx(8'h0b, {~ax[7:4], ax[3:0]}, 0);
        // writes dropped, unmapped offsets read zero
        u_host_reg_master.wr(8'h0b, 8'($urandom));
        u_host_reg_master.wr(8'h0a, 8'hff);
        rdx(8'h0b, {~ax[7:4], ax[3:0]}, 0);
        rdx(8'h0a, 8'h00, 0);
        rdx(8'h0c, 8'h00, 0);
        rdx(8'hff, 8'h00, 0);
        repeat (4) @(negedge core_clk);
        if (expQ.size() != 0) begin
            errors++;
            $display("[ERR] pending answers expected 0 seen %0d", expQ.size());
        end
        tally_and_finish();
    end
endmodule : accel_status_readout_regs_bench
`default_nettype wire

// [dv/host_reg_master.sv]
// Purpose: host-side model that issues register reads and writes
// Assumes: requests change at the falling edge, one cycle per strobe
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_reg_master (
    // clock
    input  wire logic       core_clk,
    // register port toward the device
    output var  logic       regRd,
    output var  logic       regWr,
    output var  logic [7:0] regAddr,
    output var  logic [7:0] regWrData
);
    // idle port at time zero
    initial begin
        regRd     = 1'b0;
        regWr     = 1'b0;
        regAddr   = 8'h00;
        regWrData = 8'h00;
    end

    // one read strobe; keep leaves it up so the next call makes a burst
    // the bench only calls this once reset is released, never in power-up
    task automatic rd(input logic [7:0] a, input bit keep);
        @(negedge core_clk);
        regRd   = 1'b1;
        regAddr = a;
        if (!keep) begin
            @(negedge core_clk);
            regRd   = 1'b0;
            regAddr = ~a;  // a stale address must not look valid
        end
    endtask : rd

    // one write strobe; reserved queue-flag bits always go out as zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        regWr     = 1'b1;
        regAddr   = a;
        regWrData = (a == 8'h0a) ? (d & 8'he0) : d;
        @(negedge core_clk);
        regWr     = 1'b0;
        regAddr   = ~a;
        regWrData = ~regWrData;
    endtask : wr
endmodule : host_reg_master
`default_nettype wire
